/* File: hw/pcrs_top.v */
// Design decisions made here: the address map and register access over AHB-Lite.
`default_nettype none
`include "pcrs_consts.vh"

// Functional notes
// RL1: Thirteen-bit program counter gives fetch address
// RL2: Low counter byte is software readable, writable
// RL3: Upper bits 12..8 hidden from software
// RL4: Upper bits change only from holding latch; here step carries, calls, jumps, returns and interrupts also change them
// RL5: Eight-entry, thirteen-bit hardware return stack
// RL6: Stack and pointer invisible to software
// RL7: Call or interrupt pushes program counter
// RL8: Any return kind pops top into counter
// RL9: Push and pop leave holding latch alone
// RL10: Circular stack, ninth push overwrites first
// RL11: Call/jump: 11 immediate bits, latch bits 4:3
// RL12: Low byte write loads upper from latch
module pcrs_top #(
  parameter [`PCRS_PC_W-1:0] IRQ_VECTOR = `PCRS_IRQ_VEC
) (
  // Clock and reset
  input  wire                   hclk,
  input  wire                   hresetn,
  // AHB-Lite slave
  input  wire                   hsel,
  input  wire [31:0]            haddr,
  input  wire [1:0]             htrans,
  input  wire                   hwrite,
  input  wire [2:0]             hsize,
  input  wire [31:0]            hwdata,
  input  wire                   hready,
  output wire                   hreadyout,
  output wire                   hresp,
  output reg  [31:0]            hrdata,
  // Instruction decoder and interrupt logic
  input  wire                   step_i,
  input  wire                   call_i,
  input  wire                   jump_i,
  input  wire [`PCRS_IMM_W-1:0] imm_addr_i,
  input  wire                   return_plain_i,
  input  wire                   return_with_literal_i,
  input  wire                   return_from_interrupt_i,
  input  wire                   irq_branch_i,
  // Fetch address
  output reg  [`PCRS_PC_W-1:0]  fetch_addr
);

  // Bus states, one-hot
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_WRITE = 4'h2;
  localparam [3:0] ST_RWAIT = 4'h4;
  localparam [3:0] ST_ROUT  = 4'h8;

  reg  [3:0]                 st_r;
  reg  [3:0]                 st_nxt;
  reg  [`PCRS_NUM_WORDS-1:0] wsel_r;
  reg  [`PCRS_HI_W-1:0]      lath_r;
  reg  [`PCRS_EV_W-1:0]      last_ev_r;
  reg  [31:0]                rd_mux;

  wire                       addr_ok;
  wire                       req_wr;
  wire                       req_rd;
  wire [`PCRS_NUM_WORDS-1:0] wsel_nxt;
  wire                       sw_low_wr;
  wire                       sw_lath_wr;
  wire                       ret_any;
  wire [`PCRS_PC_W-1:0]      pc_nxt;
  wire [`PCRS_PC_W-1:0]      stack_top;
  wire [`PCRS_PC_W-1:0]      push_data;
  wire                       push;
  wire                       pop;
  wire [`PCRS_EV_W-1:0]      ev;

  // Word select used by the address decode of every mapped word
  function sel_word;
    input [`PCRS_ADDR_W-1:0] a;
    input [`PCRS_ADDR_W-1:0] off;
    begin
      sel_word = (a == off);
    end
  endfunction

  // Byte address of each mapped word, by select index
  function [`PCRS_ADDR_W-1:0] word_off;
    input integer idx;
    begin
      case (idx)
        `PCRS_W_LOW: begin
          word_off = `PCRS_OFF_LOW;
        end
        `PCRS_W_LATH: begin
          word_off = `PCRS_OFF_LATH;
        end
        default: begin
          word_off = `PCRS_OFF_STAT;
        end
      endcase
    end
  endfunction

  // Next state from any state that can take a new address phase
  function [3:0] accept_next;
    input wr;
    input rd;
    begin
      if (wr) begin
        accept_next = ST_WRITE;
      end else if (rd) begin
        accept_next = ST_RWAIT;
      end else begin
        accept_next = ST_IDLE;
      end
    end
  endfunction

  // Address phase
  assign addr_ok = hsel && hready && (htrans == `PCRS_HTRANS_NSEQ);
  assign req_wr  = addr_ok && hwrite;
  assign req_rd  = addr_ok && !hwrite;

  // Reads wait one cycle so a write just before is already visible
  assign hreadyout = (st_r != ST_RWAIT);
  assign hresp     = `PCRS_HRESP_OKAY;

  // A write needs no wait: its data phase lands at the end of its own cycle.
  // A read holds hreadyout low once while the read word is registered.
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        st_nxt = accept_next(req_wr, req_rd);
      end
      ST_WRITE: begin
        st_nxt = accept_next(req_wr, req_rd);
      end
      ST_RWAIT: begin
        st_nxt = ST_ROUT;
      end
      ST_ROUT: begin
        st_nxt = accept_next(req_wr, req_rd);
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // One select bit per mapped word, decoded in the address phase
  genvar gw;
  generate
    for (gw = 0; gw < `PCRS_NUM_WORDS; gw = gw + 1) begin : g_word
      assign wsel_nxt[gw] = sel_word(haddr[`PCRS_ADDR_W-1:0], word_off(gw));
    end
  endgenerate

  // Selects are kept through the data phase; an unmapped address leaves all low
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r   <= ST_IDLE;
      wsel_r <= {`PCRS_NUM_WORDS{1'b0}};
    end else begin
      st_r <= st_nxt;
      if (addr_ok) begin
        wsel_r <= wsel_nxt;
      end
    end
  end

  // Data phase write strobes; unmapped writes are dropped with OKAY
  assign sw_low_wr  = (st_r == ST_WRITE) && wsel_r[`PCRS_W_LOW]; // see RL2
  assign sw_lath_wr = (st_r == ST_WRITE) && wsel_r[`PCRS_W_LATH];

  // Only the bus touches the latch, stack traffic never does
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lath_r <= `PCRS_LATH_RST;
    end else if (sw_lath_wr) begin
      lath_r <= hwdata[`PCRS_HI_W-1:0]; // see RL9
    end
  end

  // Upper counter bits have no word of their own; the stack has none either
  always @* begin
    rd_mux = `PCRS_WORD_ZERO;
    if (wsel_r[`PCRS_W_LOW]) begin
      rd_mux[`PCRS_LOW_W-1:0] = fetch_addr[`PCRS_LOW_W-1:0]; // see RL2 RL3
    end else if (wsel_r[`PCRS_W_LATH]) begin
      rd_mux[`PCRS_HI_W-1:0] = lath_r;
    end else if (wsel_r[`PCRS_W_STAT]) begin
      rd_mux[`PCRS_EV_W-1:0] = last_ev_r; // see RL6
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `PCRS_WORD_ZERO;
    end else if (st_r == ST_RWAIT) begin
      hrdata <= rd_mux;
    end
  end

  // Call, jump, return and interrupt outrank a bus write to the low byte in the same cycle; a step does not
  assign ret_any = return_plain_i || return_with_literal_i || return_from_interrupt_i; // see RL8

  pcrs_next_pc u_next (
    .pc        (fetch_addr),
    .lath      (lath_r),
    .stack_top (stack_top),
    .irq       (irq_branch_i),
    .call      (call_i),
    .jump      (jump_i),
    .ret_any   (ret_any),
    .sw_wr     (sw_low_wr),
    .step      (step_i),
    .imm_addr  (imm_addr_i),
    .sw_low    (hwdata[`PCRS_LOW_W-1:0]),
    .irq_vec   (IRQ_VECTOR),
    .pc_nxt    (pc_nxt),
    .push      (push),
    .pop       (pop),
    .push_data (push_data),
    .ev        (ev)
  );

  pcrs_stack #(
    .DEPTH  (`PCRS_DEPTH),
    .PTR_W  (`PCRS_PTR_W),
    .DATA_W (`PCRS_PC_W)
  ) u_stack (
    .hclk    (hclk),
    .hresetn (hresetn),
    .push    (push),
    .pop     (pop),
    .wdata   (push_data),
    .top_r   (stack_top)
  );

  // Program counter register drives the fetch address
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_addr <= `PCRS_PC_RST;
    end else begin
      fetch_addr <= pc_nxt; // see RL1 RL4
    end
  end

  // Last non-idle event, a software view of what the counter did
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_ev_r <= `PCRS_EV_NONE;
    end else if (ev != `PCRS_EV_NONE) begin
      last_ev_r <= ev;
    end
  end

endmodule // pcrs_top

`default_nettype wire

/* File: common/pcrs_consts.vh */
`ifndef PCRS_CONSTS_VH
`define PCRS_CONSTS_VH

// Program counter geometry
`define PCRS_PC_W        13
`define PCRS_LOW_W       8
`define PCRS_HI_W        5
`define PCRS_IMM_W       11
`define PCRS_PAGE_HI     4
`define PCRS_PAGE_LO     3
`define PCRS_PC_RST      13'h0000
`define PCRS_IRQ_VEC     13'h0004
`define PCRS_PC_ONE      13'h0001

// Return stack geometry
`define PCRS_DEPTH       8
`define PCRS_PTR_W       3

// Register map, byte addresses of aligned words
`define PCRS_ADDR_W      12
`define PCRS_OFF_LOW     12'h000
`define PCRS_OFF_LATH    12'h004
`define PCRS_OFF_STAT    12'h008

// Select index of each mapped word
`define PCRS_NUM_WORDS   3
`define PCRS_W_LOW       0
`define PCRS_W_LATH      1
`define PCRS_W_STAT      2
`define PCRS_LATH_RST    5'h00
`define PCRS_EV_W        4
`define PCRS_EV_NONE     4'h0

// Last event codes shown in the status word
`define PCRS_EV_STEP     4'h1
`define PCRS_EV_CALL     4'h2
`define PCRS_EV_JUMP     4'h3
`define PCRS_EV_RET      4'h4
`define PCRS_EV_IRQ      4'h5
`define PCRS_EV_SWWR     4'h6

// Bus encodings
`define PCRS_HTRANS_NSEQ 2'h2
`define PCRS_HRESP_OKAY  1'b0
`define PCRS_WORD_ZERO   32'h0000_0000

`endif

/* File: hw/pcrs_stack.v */
`default_nettype none
`include "pcrs_consts.vh"

module pcrs_stack #(
  parameter DEPTH  = `PCRS_DEPTH,
  parameter PTR_W  = `PCRS_PTR_W,
  parameter DATA_W = `PCRS_PC_W
) (
  // Clock and reset
  input  wire              hclk,
  input  wire              hresetn,
  // Push and pop
  input  wire              push,
  input  wire              pop,
  input  wire [DATA_W-1:0] wdata,
  // Top entry, from a register
  output reg  [DATA_W-1:0] top_r
);

  localparam [PTR_W-1:0] PTR_ONE = 1;
  localparam [PTR_W-1:0] PTR_TWO = 2;

  reg  [PTR_W-1:0]        ptr_r;
  wire [DEPTH*DATA_W-1:0] ent_flat;
  wire [PTR_W-1:0]        ptr_m2;

  assign ptr_m2 = ptr_r - PTR_TWO;

  // Pointer wraps with no overflow flag; the ninth push lands on the first slot
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_r <= {PTR_W{1'b0}};
    end else if (push) begin
      ptr_r <= ptr_r + PTR_ONE; // see RL10
    end else if (pop) begin
      ptr_r <= ptr_r - PTR_ONE; // see RL10
    end
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
      localparam [PTR_W-1:0] IDX = i;
      reg [DATA_W-1:0] ent_r;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ent_r <= {DATA_W{1'b0}};
        end else if (push && (ptr_r == IDX)) begin
          ent_r <= wdata; // see RL5
        end
      end
      assign ent_flat[i*DATA_W +: DATA_W] = ent_r;
    end
  endgenerate

  // Top is kept in a register so a pop can use it in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      top_r <= {DATA_W{1'b0}};
    end else if (push) begin
      top_r <= wdata;
    end else if (pop) begin
      top_r <= ent_flat[ptr_m2*DATA_W +: DATA_W];
    end
  end

endmodule // pcrs_stack

`default_nettype wire

/* File: hw/pcrs_next_pc.v */
`default_nettype none
`include "pcrs_consts.vh"

module pcrs_next_pc (
  // Current state
  input  wire [`PCRS_PC_W-1:0]  pc,
  input  wire [`PCRS_HI_W-1:0]  lath,
  input  wire [`PCRS_PC_W-1:0]  stack_top,
  // Events, highest priority first
  input  wire                   irq,
  input  wire                   call,
  input  wire                   jump,
  input  wire                   ret_any,
  input  wire                   sw_wr,
  input  wire                   step,
  input  wire [`PCRS_IMM_W-1:0] imm_addr,
  input  wire [`PCRS_LOW_W-1:0] sw_low,
  input  wire [`PCRS_PC_W-1:0]  irq_vec,
  // Results
  output reg  [`PCRS_PC_W-1:0]  pc_nxt,
  output reg                    push,
  output reg                    pop,
  output reg  [`PCRS_PC_W-1:0]  push_data,
  output reg  [`PCRS_EV_W-1:0]  ev
);

  wire [`PCRS_PC_W-1:0] pc_inc;
  wire [`PCRS_PC_W-1:0] paged;

  assign pc_inc = pc + `PCRS_PC_ONE;
  assign paged  = {lath[`PCRS_PAGE_HI:`PCRS_PAGE_LO], imm_addr}; // see RL11

  always @* begin
    pc_nxt    = pc;
    push      = 1'b0;
    pop       = 1'b0;
    push_data = pc;
    ev        = `PCRS_EV_NONE;
    if (irq) begin
      // The interrupted instruction has not run, so its own address returns
      push   = 1'b1; // see RL7
      pc_nxt = irq_vec;
      ev     = `PCRS_EV_IRQ;
    end else if (call) begin
      push      = 1'b1; // see RL7
      push_data = pc_inc;
      pc_nxt    = paged; // see RL11
      ev        = `PCRS_EV_CALL;
    end else if (jump) begin
      pc_nxt = paged; // see RL11
      ev     = `PCRS_EV_JUMP;
    end else if (ret_any) begin
      pop    = 1'b1; // see RL8
      pc_nxt = stack_top; // see RL8
      ev     = `PCRS_EV_RET;
    end else if (sw_wr) begin
      pc_nxt = {lath, sw_low}; // see RL4 RL12
      ev     = `PCRS_EV_SWWR;
    end else if (step) begin
      pc_nxt = pc_inc;
      ev     = `PCRS_EV_STEP;
    end
  end

endmodule // pcrs_next_pc

`default_nettype wire

/* File: verif/pcrs_checker.sv */
`default_nettype none
`include "pcrs_consts.vh"
module pcrs_checker #(
  parameter logic [12:0] IRQ_VECTOR = `PCRS_IRQ_VEC
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  // Core events and fetch address
  input wire logic        step_i,
  input wire logic        call_i,
  input wire logic        jump_i,
  input wire logic [10:0] imm_addr_i,
  input wire logic        return_plain_i,
  input wire logic        return_with_literal_i,
  input wire logic        return_from_interrupt_i,
  input wire logic        irq_branch_i,
  input wire logic [12:0] fetch_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       tk, ret, hi;
  logic       wr_low_r, wr_lat_r;
  logic [4:0] lat_r;
  logic [1:0] pg;
  logic [7:0] wd;
  assign tk = hsel && hready && htrans == 2'h2;
  assign ret = return_plain_i || return_with_literal_i || return_from_interrupt_i;
  assign hi = irq_branch_i || call_i || jump_i || ret;
  assign pg = lat_r[4:3];
  assign wd = hwdata[7:0];
  // Shadow of the holding latch, so branch targets can be predicted at the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_low_r <= 1'b0;
      wr_lat_r <= 1'b0;
      lat_r    <= 5'h00;
    end else begin
      wr_low_r <= tk && hwrite && haddr[11:0] == `PCRS_OFF_LOW;
      wr_lat_r <= tk && hwrite && haddr[11:0] == `PCRS_OFF_LATH;
      if (wr_lat_r)
        lat_r <= hwdata[4:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_step;
    (step_i && !hi && !wr_low_r) |=> fetch_addr == $past(fetch_addr) + 13'h0001;
  endproperty
  a_step: assert property (p_step) else $error("step did not advance");
  property p_hold;
    (!hi && !step_i && !wr_low_r) |=> $stable(fetch_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved without cause");
  property p_jump;
    (jump_i && !irq_branch_i && !call_i) |=> fetch_addr == {$past(pg), $past(imm_addr_i)};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");
  property p_low;
    (wr_low_r && !hi) |=> fetch_addr == {$past(lat_r), $past(wd)};
  endproperty
  a_low: assert property (p_low) else $error("low byte write target wrong");
  property p_call;
    (call_i && !irq_branch_i) ##1 (ret && !irq_branch_i && !call_i && !jump_i)
      |=> fetch_addr == $past(fetch_addr, 2) + 13'h0001;
  endproperty
  a_call: assert property (p_call) else $error("return after call wrong");
  property p_irq;
    irq_branch_i |=> fetch_addr == IRQ_VECTOR;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt vector wrong");
  property p_irq_ret;
    irq_branch_i ##1 (ret && !irq_branch_i && !call_i && !jump_i) |=> fetch_addr == $past(fetch_addr, 2);
  endproperty
  a_irq_ret: assert property (p_irq_ret) else $error("return after interrupt wrong");
  property p_rd;
    (tk && !hwrite) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd: assert property (p_rd) else $error("read wait state wrong");
endmodule // pcrs_checker

bind pcrs_top pcrs_checker #(.IRQ_VECTOR(IRQ_VECTOR)) u_pcrs_checker (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .step_i, .call_i, .jump_i,
  .imm_addr_i, .return_plain_i, .return_with_literal_i, .return_from_interrupt_i, .irq_branch_i, .fetch_addr);
`default_nettype wire

/* File: verif/pcrs_core_model.sv */
`default_nettype none
module pcrs_core_model (
  // Clock
  input  wire logic       hclk,
  // Events: step, call, jump, three returns, interrupt
  output var logic [6:0]  ev,
  output var logic [10:0] imm
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ev = 7'h00;
    imm = 11'h7FF;
  end
  // One event per cycle; address lines show garbage once the pulse is over
  task automatic fire(input int op, input logic [10:0] a);
    ev <= 7'h01 << op;
    imm <= a;
    @(posedge hclk);
    ev <= 7'h00;
    imm <= ~a;
  endtask
  // Two events in consecutive cycles, the second right after the first
  task automatic fire2(input int op1, input logic [10:0] a, input int op2);
    ev <= 7'h01 << op1;
    imm <= a;
    @(posedge hclk);
    ev <= 7'h01 << op2;
    imm <= ~a;
    @(posedge hclk);
    ev <= 7'h00;
    imm <= a;
  endtask
endmodule // pcrs_core_model
`default_nettype wire

/* File: verif/program_counter_and_return_stack_test.sv */
`default_nettype none
`include "pcrs_consts.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module program_counter_and_return_stack_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp;
  logic [12:0] fetch_addr;
  wire  [6:0]  ev;
  wire  [10:0] imm;
  int          errors = 0;
  int          compares = 0;
  always #25 hclk = ~hclk;
  pcrs_core_model u_pcrs_core_model (.hclk, .ev, .imm);
  pcrs_top #(.IRQ_VECTOR(`PCRS_IRQ_VEC)) u_pcrs_top (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .step_i(ev[0]), .call_i(ev[1]), .jump_i(ev[2]), .imm_addr_i(imm), .return_plain_i(ev[3]),
    .return_with_literal_i(ev[4]), .return_from_interrupt_i(ev[5]), .irq_branch_i(ev[6]), .fetch_addr);
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
    haddr <= ~haddr;
    hwdata <= ~d;
    #1;
  endtask
  task automatic ev_chk(input int op, input logic [10:0] a, input logic [12:0] exp);
    @(posedge hclk);
    u_pcrs_core_model.fire(op, a);
    #1;
    `CHK(fetch_addr, exp)
  endtask
  task automatic t_regs();
    `CHK(fetch_addr, 13'h0000)
    bus(1'b0, `PCRS_OFF_LOW, `PCRS_WORD_ZERO);
    `CHK(rd, 32'h0000_0000)
    bus(1'b1, `PCRS_OFF_LATH, 32'hFFFF_FF35);
    bus(1'b1, `PCRS_OFF_LOW, 32'hFFFF_FFA7);
    `CHK(fetch_addr, 13'h15A7)
    bus(1'b0, `PCRS_OFF_LOW, `PCRS_WORD_ZERO);
    `CHK(rd, 32'h0000_00A7)
    bus(1'b0, `PCRS_OFF_LATH, `PCRS_WORD_ZERO);
    `CHK(rd, 32'h0000_0015)
    bus(1'b0, `PCRS_OFF_STAT, `PCRS_WORD_ZERO);
    `CHK(rd[3:0], `PCRS_EV_SWWR)
    bus(1'b1, 12'hFFC, 32'hFFFF_FFFF);
    bus(1'b0, 12'hFFC, `PCRS_WORD_ZERO);
    `CHK(rd, 32'h0000_0000)
    `CHK(hresp, 1'b0)
    `CHK(fetch_addr, 13'h15A7)
  endtask
  task automatic t_branch();
    ev_chk(0, 11'h000, 13'h15A8);
    ev_chk(2, 11'h123, 13'h1123);
    ev_chk(1, 11'h456, 13'h1456);
    ev_chk(3, 11'h000, 13'h1124);
    ev_chk(6, 11'h000, `PCRS_IRQ_VEC);
    ev_chk(5, 11'h000, 13'h1124);
    bus(1'b0, `PCRS_OFF_LATH, `PCRS_WORD_ZERO);
    `CHK(rd, 32'h0000_0015)
  endtask
  task automatic t_wrap();
    logic [12:0] pc;
    logic [12:0] st[9];
    pc = 13'h1124;
    bus(1'b1, `PCRS_OFF_LATH, 32'h0000_0008);
    for (int k = 0; k < 9; k++) begin
      st[k] = pc + 13'h0001;
      pc = {2'b01, 11'h100 + 11'(k)};
      ev_chk(1, pc[10:0], pc);
    end
    // Ninth push replaced the first, so the last pop sees the newest entry again
    for (int i = 0; i < 9; i++)
      ev_chk(3 + i % 3, 11'h000, st[i < 8 ? 8 - i : 8]);
  endtask
  // Return in the cycle right after a call or an interrupt branch
  task automatic t_pair();
    @(posedge hclk);
    u_pcrs_core_model.fire2(1, 11'h222, 3);
    #1;
    `CHK(fetch_addr, 13'h0909)
    @(posedge hclk);
    u_pcrs_core_model.fire2(6, 11'h000, 5);
    #1;
    `CHK(fetch_addr, 13'h0909)
  endtask
  task automatic complete_run();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    t_regs();
    t_branch();
    t_wrap();
    t_pair();
    complete_run();
  end
  initial begin
    #100000;
    errors++;
    complete_run();
  end
endmodule // program_counter_and_return_stack_test
`default_nettype wire
